/* rtl/starter_msg_pkg.sv */
// types and constants for the starter status message logic
// assumes one clock domain, synchronous active-high reset
package starter_msg_pkg;

  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned LINK_TIMEOUT_MS   = 5000;
  localparam int unsigned LINK_TIMEOUT_CYC  = (CLK_HZ / 1000) * LINK_TIMEOUT_MS;
  localparam int unsigned ERR_W             = 8;
  localparam int unsigned WARN_W            = 8;
  localparam int unsigned PREWARN_W         = 8;
  localparam int unsigned PARAM_NUM_W       = 16;
  localparam logic [15:0] PARAM_NUM_NONE    = 16'h0000;

  typedef enum logic [1:0] {
    MODE_AUTO,
    MODE_MAN_BUS,
    MODE_MAN_LOCAL
  } ctrl_mode_t;

  // output process image as received from the master
  typedef struct packed {
    logic run_cw;
    logic run_ccw;
    logic brake;
    logic trip_reset;
  } out_image_t;

  // result of one parameter check, offered as a one-cycle event
  typedef struct packed {
    logic                   valid;
    logic                   from_master;
    logic                   bad_value;
    logic                   not_in_on;
    logic [PARAM_NUM_W-1:0] obj_num;
  } param_event_t;

  typedef struct packed {
    logic                   ready_auto;
    logic                   group_error;
    logic                   gen_warning;
    logic                   group_prewarning;
    logic                   image_error;
    logic                   bus_fault;
    logic                   master_stopped;
    logic                   reset_done;
    logic                   reset_refused;
    logic                   mode_auto;
    logic                   mode_man_bus;
    logic                   mode_man_local;
    logic                   conn_lost;
    logic                   bad_param_value;
    logic                   change_refused;
    logic [PARAM_NUM_W-1:0] bad_param_num;
    logic                   param_lock;
    logic                   expects_params;
    logic                   stats_cleared;
    logic                   outputs_blocked;
  } status_t;

endpackage

/* rtl/link_watchdog.sv */
// keep-alive watchdog: counts idle cycles while armed
// assumes kick is a one-cycle pulse on clk
`timescale 1ns/1ps
`default_nettype none
module link_watchdog #(
  parameter int unsigned TIMEOUT = starter_msg_pkg::LINK_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic armed,
  input  wire logic kick,
  output logic      expired
);
  localparam int unsigned CW = $clog2(TIMEOUT + 1);

  initial begin
    if (TIMEOUT < 2) $error("link_watchdog: TIMEOUT too small");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          expired;
  } wd_state_t;

  wd_state_t st_reg;
  wd_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!armed || kick) begin
      st_next.cnt     = '0;
      st_next.expired = 1'b0;
    end else if (st_reg.cnt == CW'(TIMEOUT)) begin
      st_next.expired = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.expired;

  property p_wd_clear;
    @(posedge clk) disable iff (sys_rst) (!armed || kick) |=> !expired;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared by kick");

endmodule
`default_nettype wire

/* rtl/starter_status_msg.sv */
// status and signaling bits of a bus-connected motor starter
// assumes only man_local_pin passes through a two-flop synchroniser here; event inputs are same-clock pulses
`timescale 1ns/1ps
`default_nettype none
module starter_status_msg #(
  parameter int unsigned TIMEOUT_CYC = starter_msg_pkg::LINK_TIMEOUT_CYC,
  parameter int unsigned ERR_N       = starter_msg_pkg::ERR_W,
  parameter int unsigned WARN_N      = starter_msg_pkg::WARN_W,
  parameter int unsigned PREWARN_N   = starter_msg_pkg::PREWARN_W
) (
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic [ERR_N-1:0]                err_cond,
  input  wire logic [ERR_N-1:0]                err_cause_active,
  input  wire logic [WARN_N-1:0]               warn_cond,
  input  wire logic [PREWARN_N-1:0]            prewarn_cond,
  input  wire starter_msg_pkg::out_image_t     out_image,
  input  wire logic                            image_valid,
  input  wire logic                            bus_timeout,
  input  wire logic                            master_run,
  input  wire logic                            trip_reset_req,
  input  wire logic                            service_req,
  input  wire logic                            man_bus_req,
  input  wire logic                            man_local_pin,
  input  wire logic                            man_bus_record,
  input  wire logic                            man_local_record,
  input  wire logic                            motor_on,
  input  wire logic                            startup_phase,
  input  wire starter_msg_pkg::param_event_t   param_evt,
  input  wire logic                            lock_on_cmd,
  input  wire logic                            lock_off_cmd,
  input  wire logic                            expect_params_cfg,
  input  wire logic                            stats_erased,
  output starter_msg_pkg::status_t             status,
  output logic                                 err_ack,
  output logic                                 param_accept_ack,
  output logic                                 param_store
);

  // any_set takes 32 bits, so wider vectors would lose their top
  initial begin
    if (ERR_N < 1 || ERR_N > 32 || WARN_N < 1 || WARN_N > 32 || PREWARN_N < 1 || PREWARN_N > 32) begin
      $error("starter_status_msg: widths must be 1 to 32");
    end
  end

  typedef struct packed {
    logic [1:0]                          pin_sync;
    starter_msg_pkg::ctrl_mode_t         mode;
    logic [ERR_N-1:0]                    err_latched;
    logic                                startup_bad;
    logic                                ack;
    logic                                accept;
    logic                                store;
    starter_msg_pkg::status_t            st;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic   link_armed;
  logic   link_kick;
  logic   link_expired;

  function automatic logic any_set(input logic [31:0] v);
    any_set = (v != 32'h0000_0000);
  endfunction

  // manual modes rely on the operator sending records in time
  // kick from the active link
  assign link_armed = (st_reg.mode != starter_msg_pkg::MODE_AUTO);
  assign link_kick  = (st_reg.mode == starter_msg_pkg::MODE_MAN_BUS) ? man_bus_record : man_local_record;

  link_watchdog #(
    .TIMEOUT (TIMEOUT_CYC)
  ) u_wd (
    .clk     (clk),
    .sys_rst (sys_rst),
    .armed   (link_armed),
    .kick    (link_kick),
    .expired (link_expired)
  );

  always_comb begin
    logic err_pending;
    logic cause_on;
    logic pevt_bad;
    err_pending = 1'b0;
    cause_on    = 1'b0;
    pevt_bad    = 1'b0;
    st_next     = st_reg;
    st_next.pin_sync = {st_reg.pin_sync[0], man_local_pin};
    st_next.ack      = 1'b0;
    st_next.accept   = 1'b0;
    st_next.store    = 1'b0;

    if (service_req || st_reg.pin_sync[1]) begin
      st_next.mode = starter_msg_pkg::MODE_MAN_LOCAL;
    end else if (man_bus_req) begin
      st_next.mode = starter_msg_pkg::MODE_MAN_BUS;
    end else begin
      st_next.mode = starter_msg_pkg::MODE_AUTO;
    end
    st_next.st.mode_auto      = (st_next.mode == starter_msg_pkg::MODE_AUTO);
    st_next.st.mode_man_bus   = (st_next.mode == starter_msg_pkg::MODE_MAN_BUS);
    st_next.st.mode_man_local = (st_next.mode == starter_msg_pkg::MODE_MAN_LOCAL);

    st_next.st.master_stopped = !master_run;
    st_next.st.bus_fault = bus_timeout;
    st_next.st.ready_auto = st_next.st.mode_auto && !bus_timeout && master_run;

    st_next.st.gen_warning      = any_set(32'(warn_cond));
    st_next.st.group_prewarning = any_set(32'(prewarn_cond));

    if (link_expired) begin
      st_next.st.conn_lost = 1'b1;
    end else if (!link_armed) begin
      st_next.st.conn_lost = 1'b0;
    end

    if (lock_on_cmd) begin
      st_next.st.param_lock = 1'b1;
    end else if (lock_off_cmd) begin
      st_next.st.param_lock = 1'b0;
    end
    st_next.st.expects_params = expect_params_cfg;

    err_pending = any_set(32'(st_reg.err_latched)) || st_reg.startup_bad;
    cause_on    = any_set(32'(st_reg.err_latched & err_cause_active)) || startup_phase;

    // trip reset handling
    if (trip_reset_req) begin
      if (err_pending && cause_on) begin
        st_next.st.reset_refused = 1'b1;
        st_next.st.reset_done    = 1'b0;
      end else begin
        if (err_pending) begin
          st_next.err_latched      = '0;
          st_next.startup_bad      = 1'b0;
          st_next.ack              = 1'b1;
          st_next.st.reset_done    = 1'b1;
          st_next.st.reset_refused = 1'b0;
        end else begin
          st_next.st.reset_done    = 1'b0;
          st_next.st.reset_refused = 1'b0;
          st_next.st.image_error   = 1'b0;
          st_next.st.conn_lost     = link_expired;
        end
        st_next.st.bad_param_value = 1'b0;
        st_next.st.change_refused  = 1'b0;
        st_next.st.bad_param_num   = starter_msg_pkg::PARAM_NUM_NONE;
        st_next.st.stats_cleared   = 1'b0;
      end
    end

    // new errors set after the clear so they are never lost
    st_next.err_latched = st_next.err_latched | err_cond;

    // after the trip clear, so a bad image wins
    if (image_valid) begin
      st_next.st.image_error = out_image.run_cw && out_image.run_ccw;
    end

    if (stats_erased) begin
      st_next.st.stats_cleared = 1'b1;
    end

    if (param_evt.valid) begin
      if (param_evt.from_master && st_reg.st.param_lock) begin
        st_next.accept = 1'b1;
      end else begin
        pevt_bad = param_evt.bad_value || (param_evt.not_in_on && motor_on);
        st_next.accept = !pevt_bad;
        st_next.store  = !pevt_bad;
        if (param_evt.bad_value) begin
          st_next.st.bad_param_value = 1'b1;
          if (startup_phase) begin
            st_next.startup_bad = 1'b1;
          end
        end
        if (param_evt.not_in_on && motor_on) begin
          st_next.st.change_refused = 1'b1;
        end
        if (pevt_bad && st_reg.st.bad_param_num == starter_msg_pkg::PARAM_NUM_NONE) begin
          st_next.st.bad_param_num = param_evt.obj_num;
        end
      end
    end

    st_next.st.group_error     = any_set(32'(st_next.err_latched)) || st_next.startup_bad;
    st_next.st.outputs_blocked = st_next.startup_bad;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.mode <= starter_msg_pkg::MODE_AUTO;
      st_reg.st.mode_auto <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status           = st_reg.st;
  assign err_ack          = st_reg.ack;
  assign param_accept_ack = st_reg.accept;
  assign param_store      = st_reg.store;

  property p_cw_ccw;
    @(posedge clk) disable iff (sys_rst) image_valid && out_image.run_cw && out_image.run_ccw
      |=> status.image_error;
  endproperty
  a_cw_ccw: assert property (p_cw_ccw) else $error("forbidden image not flagged");

  property p_one_mode;
    @(posedge clk) disable iff (sys_rst) $onehot({status.mode_auto, status.mode_man_bus, status.mode_man_local});
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode bits not one-hot");

  property p_service_top;
    @(posedge clk) disable iff (sys_rst) service_req |=> status.mode_man_local;
  endproperty
  a_service_top: assert property (p_service_top) else $error("service request lost priority");

  property p_err_group;
    @(posedge clk) disable iff (sys_rst) err_cond != '0 |=> status.group_error;
  endproperty
  a_err_group: assert property (p_err_group) else $error("group error missing");

  property p_warn;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> status.gen_warning == ($past(warn_cond) != '0);
  endproperty
  a_warn: assert property (p_warn) else $error("warning flag mismatch");

  property p_prewarn;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> status.group_prewarning == ($past(prewarn_cond) != '0);
  endproperty
  a_prewarn: assert property (p_prewarn) else $error("prewarning flag mismatch");

  property p_lock_discard;
    @(posedge clk) disable iff (sys_rst) param_evt.valid && param_evt.from_master && status.param_lock
      |=> param_accept_ack && !param_store;
  endproperty
  a_lock_discard: assert property (p_lock_discard) else $error("locked master params stored");

  property p_refuse;
    @(posedge clk) disable iff (sys_rst) trip_reset_req && status.group_error && startup_phase
      |=> status.reset_refused && !err_ack;
  endproperty
  a_refuse: assert property (p_refuse) else $error("reset accepted while cause present");

  property p_run_change;
    @(posedge clk) disable iff (sys_rst)
      param_evt.valid && param_evt.not_in_on && motor_on && !status.param_lock
      |=> status.change_refused;
  endproperty
  a_run_change: assert property (p_run_change) else $error("run change not refused");

  property p_stats;
    @(posedge clk) disable iff (sys_rst) stats_erased |=> status.stats_cleared;
  endproperty
  a_stats: assert property (p_stats) else $error("stats cleared not set");

  property p_bus;
    @(posedge clk) disable iff (sys_rst) bus_timeout |=> status.bus_fault && !status.ready_auto;
  endproperty
  a_bus: assert property (p_bus) else $error("bus fault not flagged");

  property p_ack_done;
    @(posedge clk) disable iff (sys_rst) err_ack |-> status.reset_done && !status.reset_refused;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("acknowledge without reset done");

  property p_master_stop;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> status.master_stopped == !$past(master_run);
  endproperty
  a_master_stop: assert property (p_master_stop) else $error("master stop flag mismatch");

  property p_ready;
    @(posedge clk) disable iff (sys_rst)
      status.ready_auto |-> status.mode_auto && !status.bus_fault && !status.master_stopped;
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag without bus control");

  // later refusals must not overwrite the first number
  property p_first_num;
    @(posedge clk) disable iff (sys_rst)
      status.bad_param_num != starter_msg_pkg::PARAM_NUM_NONE && !trip_reset_req
      |=> $stable(status.bad_param_num);
  endproperty
  a_first_num: assert property (p_first_num) else $error("first refused number overwritten");

  property p_startup_block;
    @(posedge clk) disable iff (sys_rst)
      param_evt.valid && param_evt.bad_value && startup_phase && !(param_evt.from_master && status.param_lock)
      |=> status.outputs_blocked && status.group_error && status.bad_param_value;
  endproperty
  a_startup_block: assert property (p_startup_block) else $error("startup parameter fault not blocking");

  property p_conn_lost;
    @(posedge clk) disable iff (sys_rst) link_expired |=> status.conn_lost;
  endproperty
  a_conn_lost: assert property (p_conn_lost) else $error("lost link not flagged");

  property p_trip_clear;
    @(posedge clk) disable iff (sys_rst)
      trip_reset_req && !status.group_error && !stats_erased && !param_evt.valid
      |=> !status.stats_cleared && !status.change_refused && !status.bad_param_value && !status.reset_done;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("trip reset left signaling bits");

  property p_expects;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> status.expects_params == $past(expect_params_cfg);
  endproperty
  a_expects: assert property (p_expects) else $error("parameter expectation flag mismatch");

endmodule
`default_nettype wire

/* sim/keepalive_partner.sv */
// far side model: operator tool that keeps a manual-mode link alive
// assumes clk is the block clock; records are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module keepalive_partner #(
  parameter int unsigned PERIOD = 8
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic to_local,
  output var logic  bus_rec   = 1'b0,
  output var logic  local_rec = 1'b0
);
  int unsigned cnt = 0;

  // record within timeout
  // period kept well under the block timeout so one late record never trips it
  always @(posedge clk) begin
    bus_rec   <= 1'b0;
    local_rec <= 1'b0;
    if (sys_rst || !enable) begin
      cnt <= 0;
    end else if (cnt == PERIOD - 1) begin
      cnt       <= 0;
      bus_rec   <= !to_local;
      local_rec <= to_local;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the starter status message logic
// assumes short link timeout of 20 cycles and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned TO = 20;
  typedef struct {
    logic [7:0] w;
    logic [7:0] p;
    logic       bt;
    logic       mr;
    logic       ec;
    logic [5:0] ex;
  } row_t;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic [7:0] err_cond = 8'h00, err_cause_active = 8'h00, warn_cond = 8'h00, prewarn_cond = 8'h00;
  starter_msg_pkg::out_image_t   out_image = '0;
  starter_msg_pkg::param_event_t pe        = '0;
  starter_msg_pkg::status_t      st, ex;
  logic image_valid = 1'b0, bus_timeout = 1'b0, master_run = 1'b1, trip_reset_req = 1'b0;
  logic service_req = 1'b0, man_bus_req = 1'b0, man_local_pin = 1'b0, motor_on = 1'b1;
  logic startup_phase = 1'b0, lock_on_cmd = 1'b0, lock_off_cmd = 1'b0, expect_params_cfg = 1'b0;
  logic stats_erased = 1'b0, ka_en = 1'b0, ka_local = 1'b0;
  logic bus_rec, local_rec, err_ack, param_accept_ack, param_store;
  int err_total = 0, n_compared = 0;
  row_t rows[5] = '{
    '{8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 6'h20}, '{8'h80, 8'h00, 1'b0, 1'b1, 1'b1, 6'h31},
    '{8'h00, 8'h01, 1'b1, 1'b1, 1'b0, 6'h0c}, '{8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 6'h02},
    '{8'hff, 8'hff, 1'b1, 1'b0, 1'b1, 6'h1f}};

  starter_status_msg #(.TIMEOUT_CYC(TO)) dut (
    .clk(clk), .sys_rst(sys_rst), .err_cond(err_cond), .err_cause_active(err_cause_active),
    .warn_cond(warn_cond), .prewarn_cond(prewarn_cond), .out_image(out_image), .image_valid(image_valid),
    .bus_timeout(bus_timeout), .master_run(master_run), .trip_reset_req(trip_reset_req),
    .service_req(service_req), .man_bus_req(man_bus_req), .man_local_pin(man_local_pin),
    .man_bus_record(bus_rec), .man_local_record(local_rec), .motor_on(motor_on),
    .startup_phase(startup_phase), .param_evt(pe), .lock_on_cmd(lock_on_cmd), .lock_off_cmd(lock_off_cmd),
    .expect_params_cfg(expect_params_cfg), .stats_erased(stats_erased), .status(st), .err_ack(err_ack),
    .param_accept_ack(param_accept_ack), .param_store(param_store));

  keepalive_partner #(.PERIOD(8)) partner (
    .clk(clk), .sys_rst(sys_rst), .enable(ka_en), .to_local(ka_local), .bus_rec(bus_rec), .local_rec(local_rec));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one edge: pulses drop back, then let the edge's updates settle
  task automatic edge1();
    @(posedge clk);
    image_valid    <= 1'b0;
    trip_reset_req <= 1'b0;
    lock_on_cmd    <= 1'b0;
    lock_off_cmd   <= 1'b0;
    stats_erased   <= 1'b0;
    err_cond       <= 8'h00;
    pe.valid       <= 1'b0;
    #1;
  endtask

  task automatic wait_n(input int n);
    repeat (n) edge1();
  endtask

  task automatic trip();
    @(posedge clk);
    trip_reset_req <= 1'b1;
    edge1();
  endtask

  task automatic param(input logic fm, input logic bad, input logic non, input logic [15:0] num);
    @(posedge clk);
    pe <= '{1'b1, fm, bad, non, num};
    edge1();
  endtask

  task automatic conclude();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    ex = '0;
    ex.mode_auto = 1'b1;
    repeat (9) @(posedge clk);
    #1 chk(st, ex);
    @(posedge clk);
    sys_rst <= 1'b0;
    wait_n(2);
    foreach (rows[i]) begin
      @(posedge clk);
      {warn_cond, prewarn_cond, bus_timeout, master_run, expect_params_cfg} <=
        {rows[i].w, rows[i].p, rows[i].bt, rows[i].mr, rows[i].ec};
      edge1();
      chk({st.ready_auto, st.gen_warning, st.group_prewarning, st.bus_fault, st.master_stopped,
           st.expects_params}, rows[i].ex);
    end
    @(posedge clk);
    {warn_cond, prewarn_cond, bus_timeout, master_run} <= {8'h00, 8'h00, 1'b0, 1'b1};
    // latched error, refused while its cause stands
    @(posedge clk);
    err_cause_active <= 8'h08;
    err_cond         <= 8'h08;
    edge1();
    chk(st.group_error, 1'b1);
    trip();
    chk({st.reset_refused, err_ack, st.group_error}, 3'b101);
    @(posedge clk);
    err_cause_active <= 8'h00;
    trip();
    chk({err_ack, st.reset_done, st.group_error}, 3'b110);
    edge1();
    chk(err_ack, 1'b0);
    // forbidden image, then a clean one
    @(posedge clk);
    out_image   <= '{1'b1, 1'b1, 1'b0, 1'b0};
    image_valid <= 1'b1;
    edge1();
    chk(st.image_error, 1'b1);
    @(posedge clk);
    out_image   <= '{1'b1, 1'b0, 1'b0, 1'b0};
    image_valid <= 1'b1;
    edge1();
    chk(st.image_error, 1'b0);
    // parameter refusals while running; first number sticks
    param(1'b0, 1'b0, 1'b1, 16'h0012);
    chk({st.change_refused, st.group_error, st.outputs_blocked, st.bad_param_num}, 32'h40012);
    param(1'b0, 1'b1, 1'b0, 16'h0034);
    chk({st.bad_param_value, st.bad_param_num}, 32'h10012);
    @(posedge clk);
    stats_erased <= 1'b1;
    edge1();
    chk(st.stats_cleared, 1'b1);
    trip();
    chk({err_ack, st.change_refused, st.bad_param_value, st.stats_cleared, st.reset_done, st.bad_param_num}, 0);
    // master lock
    @(posedge clk);
    lock_on_cmd <= 1'b1;
    edge1();
    chk(st.param_lock, 1'b1);
    param(1'b1, 1'b0, 1'b0, 16'h0005);
    chk({param_accept_ack, param_store}, 2'b10);
    @(posedge clk);
    lock_off_cmd <= 1'b1;
    edge1();
    param(1'b1, 1'b0, 1'b0, 16'h0005);
    chk({st.param_lock, param_accept_ack, param_store}, 3'b011);
    // control modes and priority
    @(posedge clk);
    man_bus_req <= 1'b1;
    ka_en       <= 1'b1;
    edge1();
    chk({st.mode_auto, st.mode_man_bus, st.mode_man_local, st.ready_auto}, 4'b0100);
    wait_n(60);
    chk(st.conn_lost, 1'b0);
    @(posedge clk);
    ka_en <= 1'b0;
    wait_n(TO + 4);
    chk(st.conn_lost, 1'b1);
    @(posedge clk);
    service_req <= 1'b1;
    edge1();
    chk({st.mode_auto, st.mode_man_bus, st.mode_man_local}, 3'b001);
    @(posedge clk);
    {service_req, man_bus_req, man_local_pin} <= 3'b001;
    wait_n(4);
    chk({st.mode_auto, st.mode_man_bus, st.mode_man_local}, 3'b001);
    @(posedge clk);
    man_local_pin <= 1'b0;
    wait_n(4);
    chk({st.mode_auto, st.conn_lost}, 2'b10);
    // bad parameter during power-up
    @(posedge clk);
    startup_phase <= 1'b1;
    param(1'b0, 1'b1, 1'b0, 16'h0040);
    chk({st.group_error, st.bad_param_value, st.outputs_blocked}, 3'b111);
    trip();
    chk({st.reset_refused, err_ack, st.group_error}, 3'b101);
    // mid-run reset returns every flag to idle
    @(posedge clk);
    sys_rst       <= 1'b1;
    startup_phase <= 1'b0;
    wait_n(2);
    chk(st, ex);
    chk({err_ack, param_accept_ack, param_store}, 3'b000);
    @(posedge clk);
    sys_rst <= 1'b0;
    edge1();
    chk({st.mode_auto, st.ready_auto, st.group_error, st.outputs_blocked}, 4'b1100);
    conclude();
  end
endmodule
`default_nettype wire
